//--- rtl/bsid_pkg.sv
// shared constants and types for the test access port block
package bsid_pkg;
    localparam int IR_W = 4;
    localparam int ID_W = 32;
    // instruction encodings
    localparam logic [3:0] INS_EXTEST = 4'h0;
    localparam logic [3:0] INS_SAMPLE = 4'h1;
    localparam logic [3:0] INS_IDCODE = 4'h2;
    localparam logic [3:0] INS_HIGHZ = 4'h4;
    localparam logic [3:0] INS_BYPASS = 4'hf;
    // capture pattern loaded in capture-ir, low bits 01
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    // identity word field positions
    localparam int VER_LSB = 28;
    localparam int PART_LSB = 12;
    localparam int MAKER_LSB = 1;
    // five tck with tms high reach test-logic-reset
    localparam int TLR_TMS_CYCLES = 5;
    // tap states
    typedef enum logic [3:0] {
        ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
        ST_SHF_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PAU_DR = 4'h6, ST_EX2_DR = 4'h7,
        ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SHF_IR = 4'hb,
        ST_EX1_IR = 4'hc, ST_PAU_IR = 4'hd, ST_EX2_IR = 4'he, ST_UPD_IR = 4'hf
    } bsid_state_t;
    // decoded mode carried to the system side
    typedef struct packed {
        logic ext_mode;
        logic outs_off;
    } bsid_mode_t;
endpackage : bsid_pkg

//--- rtl/bsid_tap.sv
// test access port: tap controller, instruction, identity, bypass, boundary chain
`timescale 1ns/1ns
module bsid_tap
    import bsid_pkg::*;
#(
    parameter int BSR_W = 8,
    parameter logic [3:0] VERSION = 4'h0,      // arbitrary value
    parameter logic [15:0] PART_NUM = 16'h0abc, // arbitrary value
    parameter logic [10:0] MAKER = 11'h055     // arbitrary value
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic trstn_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    input wire logic [BSR_W-1:0] pin_in_i,
    input wire logic [BSR_W-1:0] core_out_i,
    output logic [BSR_W-1:0] pin_out_o,
    output logic pin_oe_o,
    output logic ext_mode_o,
    output logic outs_off_o
);
    // identity word assembled from fixed fields
    // field layout
    localparam logic [ID_W-1:0] ID_WORD = {VERSION, PART_NUM, MAKER, 1'b1};

    bsid_state_t state_ff;
    bsid_state_t nxt_state;
    logic [IR_W-1:0] ir_shift_ff;
    logic [IR_W-1:0] ir_cur_ff;
    logic [ID_W-1:0] id_shift_ff;
    logic byp_ff;
    logic [BSR_W-1:0] bsr_shift_ff;
    logic [BSR_W-1:0] bsr_upd_ff;
    logic tdo_ff;
    logic tdo_oe_ff;
    bsid_mode_t mode_tck_ff;
    bsid_mode_t mode_s1_ff;
    bsid_mode_t mode_s2_ff;
    logic [2:0] tms_hi_ff;

    // instruction decode, used only by the mode flop
    function automatic bsid_mode_t decode_mode(input logic [IR_W-1:0] ins);
        bsid_mode_t m;
        m.ext_mode = (ins == INS_EXTEST);
        m.outs_off = (ins == INS_HIGHZ);
        return m;
    endfunction : decode_mode

    // tap next-state logic
    always_comb begin
        case (state_ff)
            ST_TLR: nxt_state = tms_i ? ST_TLR : ST_RTI;
            ST_RTI: nxt_state = tms_i ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: nxt_state = tms_i ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: nxt_state = tms_i ? ST_EX1_DR : ST_SHF_DR;
            ST_SHF_DR: nxt_state = tms_i ? ST_EX1_DR : ST_SHF_DR;
            ST_EX1_DR: nxt_state = tms_i ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: nxt_state = tms_i ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: nxt_state = tms_i ? ST_UPD_DR : ST_SHF_DR;
            ST_UPD_DR: nxt_state = tms_i ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: nxt_state = tms_i ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: nxt_state = tms_i ? ST_EX1_IR : ST_SHF_IR;
            ST_SHF_IR: nxt_state = tms_i ? ST_EX1_IR : ST_SHF_IR;
            ST_EX1_IR: nxt_state = tms_i ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: nxt_state = tms_i ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: nxt_state = tms_i ? ST_UPD_IR : ST_SHF_IR;
            ST_UPD_IR: nxt_state = tms_i ? ST_SEL_DR : ST_RTI;
            default: nxt_state = ST_TLR;
        endcase
    end

    // tap state register; trst acts as a synchronous reset on tck
    // tap reset paths
    always_ff @(posedge tck_i) begin
        if (!trstn_i) begin
            state_ff <= ST_TLR;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // count of consecutive tms-high edges, for checking only
    always_ff @(posedge tck_i) begin
        if (!trstn_i || !tms_i) begin
            tms_hi_ff <= 3'h0;
        end else if (tms_hi_ff != 3'h7) begin
            tms_hi_ff <= tms_hi_ff + 3'h1;
        end
    end

    // instruction shift stage
    // capture pattern
    always_ff @(posedge tck_i) begin
        if (!trstn_i) begin
            ir_shift_ff <= IR_CAPTURE;
        end else if (state_ff == ST_CAP_IR) begin
            ir_shift_ff <= IR_CAPTURE;
        end else if (state_ff == ST_SHF_IR) begin
            ir_shift_ff <= {tdi_i, ir_shift_ff[IR_W-1:1]};
        end
    end

    // current instruction latched on falling tck in update-ir
    // reset selects identity read
    always_ff @(negedge tck_i) begin
        if (!trstn_i || state_ff == ST_TLR) begin
            ir_cur_ff <= INS_IDCODE;
        end else if (state_ff == ST_UPD_IR) begin
            ir_cur_ff <= ir_shift_ff;
        end
    end

    // identity shift register, touched only when selected
    // read-only identity
    // no effect on function
    // test reset loads the identity word so hold checks never see unknowns
    always_ff @(posedge tck_i) begin
        if (!trstn_i) begin
            id_shift_ff <= ID_WORD;
        end else if (ir_cur_ff == INS_IDCODE) begin
            if (state_ff == ST_CAP_DR) begin
                id_shift_ff <= ID_WORD;
            end else if (state_ff == ST_SHF_DR) begin
                id_shift_ff <= {tdi_i, id_shift_ff[ID_W-1:1]};
            end
        end
    end

    // one-bit bypass stage, used by bypass, high-z and unknown codes
    // capture zero
    always_ff @(posedge tck_i) begin
        if (!trstn_i) begin
            byp_ff <= 1'b0;
        end else if (state_ff == ST_CAP_DR) begin
            byp_ff <= 1'b0;
        end else if (state_ff == ST_SHF_DR) begin
            byp_ff <= tdi_i;
        end
    end

    // boundary chain shift stage; only extest and sample touch it
    // capture pin inputs in extest, core data in sample
    always_ff @(posedge tck_i) begin
        if (!trstn_i) begin
            bsr_shift_ff <= '0;
        end else if (ir_cur_ff == INS_EXTEST || ir_cur_ff == INS_SAMPLE) begin
            if (state_ff == ST_CAP_DR) begin
                bsr_shift_ff <= (ir_cur_ff == INS_EXTEST) ? pin_in_i : core_out_i;
            end else if (state_ff == ST_SHF_DR) begin
                bsr_shift_ff <= {tdi_i, bsr_shift_ff[BSR_W-1:1]};
            end
        end
    end

    // boundary update stage; keeps preload across the switch to extest
    // preload retained
    always_ff @(negedge tck_i) begin
        if (!trstn_i) begin
            bsr_upd_ff <= '0;
        end else if (state_ff == ST_UPD_DR &&
                     (ir_cur_ff == INS_EXTEST || ir_cur_ff == INS_SAMPLE)) begin
            bsr_upd_ff <= bsr_shift_ff;
        end
    end

    // serial output mux, changes on falling tck
    // path select
    always_ff @(negedge tck_i) begin
        if (!trstn_i) begin
            tdo_ff <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else begin
            tdo_oe_ff <= (state_ff == ST_SHF_DR) || (state_ff == ST_SHF_IR);
            if (state_ff == ST_SHF_IR) begin
                tdo_ff <= ir_shift_ff[0];
            end else begin
                case (ir_cur_ff)
                    INS_EXTEST, INS_SAMPLE: tdo_ff <= bsr_shift_ff[0];
                    INS_IDCODE: tdo_ff <= id_shift_ff[0];
                    default: tdo_ff <= byp_ff;
                endcase
            end
        end
    end

    assign tdo_o = tdo_ff;
    assign tdo_oe_o = tdo_oe_ff;

    // mode decoded into a tck-domain flop, crossed as levels into sys_clk;
    // a flop here keeps decode glitches away from the synchroniser
    always_ff @(negedge tck_i) begin
        if (!trstn_i || state_ff == ST_TLR) begin
            mode_tck_ff <= '0;
        end else if (state_ff == ST_UPD_IR) begin
            mode_tck_ff <= decode_mode(ir_shift_ff);
        end
    end

    // two-flop synchroniser per mode bit
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            mode_s1_ff <= '0;
            mode_s2_ff <= '0;
        end else begin
            mode_s1_ff <= mode_tck_ff;
            mode_s2_ff <= mode_s1_ff;
        end
    end

    // pin drive: boundary value in extest, all off in high-z
    // outputs disabled
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            pin_out_o <= '0;
            pin_oe_o <= 1'b1;
        end else begin
            pin_out_o <= mode_s2_ff.ext_mode ? bsr_upd_ff : core_out_i;
            pin_oe_o <= !mode_s2_ff.outs_off;
        end
    end

    assign ext_mode_o = mode_s2_ff.ext_mode;
    assign outs_off_o = mode_s2_ff.outs_off;

    // five tms-high edges always land in test-logic-reset
    // tms reset
    tms_reset_a: assert property (@(posedge tck_i) disable iff (!trstn_i)
        tms_hi_ff >= 3'(TLR_TMS_CYCLES) |-> state_ff == ST_TLR)
        else $error("five tms high did not reset tap");

    // capture-ir loads the fixed pattern
    ir_capture_a: assert property (@(posedge tck_i) disable iff (!trstn_i)
        state_ff == ST_CAP_IR |=> ir_shift_ff[1:0] == 2'b01)
        else $error("capture-ir pattern wrong");

    // shift register holds outside shift and capture
    ir_hold_a: assert property (@(posedge tck_i) disable iff (!trstn_i)
        state_ff != ST_SHF_IR && state_ff != ST_CAP_IR |=> $stable(ir_shift_ff))
        else $error("instruction shifted outside shift-ir");

    // bypass loads zero at capture-dr
    byp_capture_a: assert property (@(posedge tck_i) disable iff (!trstn_i)
        state_ff == ST_CAP_DR |=> !byp_ff)
        else $error("bypass stage not zero after capture");

    // identity capture yields the fixed word with bit 0 set
    id_capture_a: assert property (@(posedge tck_i) disable iff (!trstn_i)
        state_ff == ST_CAP_DR && ir_cur_ff == INS_IDCODE |=>
        id_shift_ff == ID_WORD && id_shift_ff[0])
        else $error("identity capture wrong");

    // boundary chain untouched under other instructions
    bsr_quiet_a: assert property (@(posedge tck_i) disable iff (!trstn_i)
        ir_cur_ff != INS_EXTEST && ir_cur_ff != INS_SAMPLE |=> $stable(bsr_shift_ff))
        else $error("boundary chain disturbed");

    // high-z keeps outputs off while it lasts
    highz_off_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        mode_s2_ff.outs_off |=> !pin_oe_o)
        else $error("outputs driven under high-z");

    // outside extest the pins follow core data
    func_pins_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !mode_s2_ff.ext_mode |=> pin_out_o == $past(core_out_i))
        else $error("pins not in functional mode");

    // serial output enabled during data shifts
    tdo_enable_a: assert property (@(negedge tck_i) disable iff (!trstn_i)
        state_ff == ST_SHF_DR |=> tdo_oe_o)
        else $error("tdo not enabled in shift-dr");

    // update-ir makes the shifted code current
    ir_latch_a: assert property (@(negedge tck_i) disable iff (!trstn_i)
        state_ff == ST_UPD_IR |=> ir_cur_ff == $past(ir_shift_ff))
        else $error("instruction not latched in update-ir");

    // test-logic-reset selects the identity read
    tlr_idcode_a: assert property (@(negedge tck_i) disable iff (!trstn_i)
        state_ff == ST_TLR |=> ir_cur_ff == INS_IDCODE)
        else $error("reset did not select identity");

    // test reset forces test-logic-reset
    trst_state_a: assert property (@(posedge tck_i)
        !trstn_i |=> state_ff == ST_TLR)
        else $error("trst did not reset tap");

    // bypass stage takes tdi in shift-dr
    byp_shift_a: assert property (@(posedge tck_i) disable iff (!trstn_i)
        state_ff == ST_SHF_DR |=> byp_ff == $past(tdi_i))
        else $error("bypass stage did not shift");

    // identity register shifts tdi into its msb
    id_shift_a: assert property (@(posedge tck_i) disable iff (!trstn_i)
        state_ff == ST_SHF_DR && ir_cur_ff == INS_IDCODE |=>
        id_shift_ff[ID_W-1] == $past(tdi_i))
        else $error("identity register did not shift");

    // identity register left alone under other codes
    id_quiet_a: assert property (@(posedge tck_i) disable iff (!trstn_i)
        ir_cur_ff != INS_IDCODE |=> $stable(id_shift_ff))
        else $error("identity register disturbed");

    // outputs stay enabled outside high-z
    oe_normal_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !mode_s2_ff.outs_off |=> pin_oe_o)
        else $error("outputs disabled outside high-z");

    // extest drives pins from the update stage
    ext_pins_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        mode_s2_ff.ext_mode |=> pin_out_o == $past(bsr_upd_ff))
        else $error("pins not driven from boundary chain");
endmodule : bsid_tap

//--- tb/bsid_ctl.sv
// test controller model driving the test port
`timescale 1ns/1ns
module bsid_ctl (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    output logic trstn_o,
    input wire logic tdo_i
);
    // tck idles low outside frames
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        trstn_o = 1'b1;
    end
    // one 48 ns tck period, tdo taken just before the rising edge
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #24;
        tdo = tdo_i;
        tck_o = 1'b1;
        #24;
        tck_o = 1'b0;
        tdi_o = ~tdi; // released line shows no stale value
    endtask : step
    // reset by trst, ends in run-test-idle
    task automatic trst_reset();
        logic d;
        trstn_o = 1'b0;
        repeat (2) step(1'b1, 1'b0, d);
        trstn_o = 1'b1;
        step(1'b0, 1'b0, d);
    endtask : trst_reset
    // reset by five tck with tms high
    task automatic tms_reset();
        logic d;
        repeat (5) step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
    endtask : tms_reset
    // ir or dr scan from run-test-idle back to run-test-idle
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
                        output logic [31:0] dout);
        logic d;
        dout = 32'h0;
        step(1'b1, 1'b0, d);
        if (ir) step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
        step(1'b0, 1'b0, d);
        // shift lsb first, leave on the last bit
        for (int k = 0; k < n; k++) begin
            step(logic'(k == n - 1), din[k], d);
            dout[k] = d;
        end
        step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
    endtask : scan
endmodule : bsid_ctl

//--- tb/tb_top.sv
// self-checking bench for the test access port
`timescale 1ns/1ns
module tb_top;
    import bsid_pkg::*;
    localparam logic [31:0] ID_EXP = {4'h5, 16'h1234, 11'h2a5, 1'b1};
    logic sys_clk_i, resetn_i, tck_i, tms_i, tdi_i, trstn_i, tdo_o;
    logic pin_oe_o, ext_mode_o, outs_off_o;
    logic [7:0] pin_in_i, core_out_i, pin_out_o;
    logic [3:0] byp [3] = '{4'hf, 4'h7, 4'h3};
    int n_errors = 0;
    int checks_done = 0;
    bsid_tap #(.VERSION(4'h5), .PART_NUM(16'h1234), .MAKER(11'h2a5)) i_bsid_tap (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .tck_i(tck_i), .tms_i(tms_i),
        .tdi_i(tdi_i), .trstn_i(trstn_i), .tdo_o(tdo_o), .tdo_oe_o(),
        .pin_in_i(pin_in_i), .core_out_i(core_out_i), .pin_out_o(pin_out_o),
        .pin_oe_o(pin_oe_o), .ext_mode_o(ext_mode_o), .outs_off_o(outs_off_o));
    bsid_ctl i_bsid_ctl (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .trstn_o(trstn_i),
        .tdo_i(tdo_o));
    // 250 mhz system clock
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    // compare and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // mode outputs cross domains, so allow the sync stages to land
    task automatic modes(input logic [31:0] exp);
        repeat (8) @(posedge sys_clk_i);
        chk("modes", exp, {21'h0, ext_mode_o, outs_off_o, pin_oe_o, pin_out_o});
    endtask : modes
    // load an instruction, checking the captured pattern
    task automatic load_ir(input logic [3:0] code);
        logic [31:0] q;
        i_bsid_ctl.scan(1'b1, {28'h0, code}, 4, q);
        chk("ir capture", 32'h1, q);
    endtask : load_ir
    // verdict and end of run
    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    // main sequence
    initial begin
        logic [31:0] q;
        resetn_i = 1'b0;
        pin_in_i = 8'h69;
        core_out_i = 8'ha5;
        repeat (3) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        i_bsid_ctl.trst_reset();
        i_bsid_ctl.scan(1'b0, 32'h0, 32, q);
        chk("idcode after trst", ID_EXP, q);
        modes(32'h1a5);
        // bypass and unlisted codes: one-bit stage, zero captured first
        foreach (byp[i]) begin
            load_ir(byp[i]);
            i_bsid_ctl.scan(1'b0, 32'hb, 4, q);
            chk("bypass path", 32'h6, q);
            modes(32'h1a5);
        end
        i_bsid_ctl.tms_reset();
        i_bsid_ctl.scan(1'b0, 32'h0, 32, q);
        chk("idcode after tms reset", ID_EXP, q);
        load_ir(INS_IDCODE);
        i_bsid_ctl.scan(1'b0, 32'h0, 32, q);
        chk("idcode word", ID_EXP, q);
        modes(32'h1a5);
        // high-z: outputs off before and after a shift
        load_ir(INS_HIGHZ);
        modes(32'h2a5);
        i_bsid_ctl.scan(1'b0, 32'hb, 4, q);
        chk("high-z bypass", 32'h6, q);
        modes(32'h2a5);
        // sample snapshots core data and preloads the update stage
        load_ir(INS_SAMPLE);
        i_bsid_ctl.scan(1'b0, 32'h3c, 8, q);
        chk("sample capture", 32'ha5, q);
        modes(32'h1a5);
        // extest drives the preload and captures pin inputs
        load_ir(INS_EXTEST);
        modes(32'h53c);
        i_bsid_ctl.scan(1'b0, 32'h0, 8, q);
        chk("extest capture", 32'h69, q);
        modes(32'h500);
        end_sim();
    end
endmodule : tb_top
